// File: bench/tb.sv
// self-checking bench of the endpoint responder: register port, tokens, data, host replies
// assumes the host model drives the packet-engine inputs; everything runs on one clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, reset, regWrite, regRead;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, v;
  logic tokenStrobe, tokenAddrOk, dataStart, dataEnd, rxToggle, rxCrcOk, rxErrFree;
  logic [1:0] tokenPid, tokenEp, hsCode, gCode;
  logic [4:0] rxBytes;
  logic hostAck, hostLost, hsStrobe, txStrobe, txToggle, gHs, gTx, gTog, t;
  logic [3:0] txBytes, gBytes, n;
  logic [2:0] epEvent, gEv;
  int n_fail, checks_done;
  uepr_responder i_uepr_responder (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .tokenStrobe(tokenStrobe), .tokenPid(tokenPid), .tokenEp(tokenEp),
    .tokenAddrOk(tokenAddrOk), .dataStart(dataStart), .dataEnd(dataEnd), .rxBytes(rxBytes),
    .rxToggle(rxToggle), .rxCrcOk(rxCrcOk), .rxErrFree(rxErrFree), .hostAck(hostAck),
    .hostLost(hostLost), .hsStrobe(hsStrobe), .hsCode(hsCode), .txStrobe(txStrobe),
    .txBytes(txBytes), .txToggle(txToggle), .epEvent(epEvent));
  uepr_host_model i_uepr_host_model (.clock(clock), .tokenStrobe(tokenStrobe),
    .tokenPid(tokenPid), .tokenEp(tokenEp), .tokenAddrOk(tokenAddrOk), .dataStart(dataStart),
    .dataEnd(dataEnd), .rxBytes(rxBytes), .rxToggle(rxToggle), .rxCrcOk(rxCrcOk),
    .rxErrFree(rxErrFree), .hostAck(hostAck), .hostLost(hostLost));
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // verdict, reached from the main sequence or the watchdog
  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // register port: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    {regWrite, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    d = regRdData;
  endtask
  // collect every answer pulse over a fixed window, sampled mid-cycle
  task automatic watch(input int cycles);
    {gHs, gTx, gEv} = '0;
    repeat (cycles) begin
      @(negedge clock);
      if (hsStrobe === 1'b1) {gHs, gCode} = {1'b1, hsCode};
      if (txStrobe === 1'b1) {gTx, gBytes, gTog} = {1'b1, txBytes, txToggle};
      gEv = gEv | epEvent;
    end
  endtask
  task automatic resp(input logic h, input logic [1:0] c, input logic x, input logic [3:0] b,
                      input logic [2:0] e);
    chk({7'h0, gHs}, {7'h0, h});
    if (h) chk({6'h0, gCode}, {6'h0, c});
    chk({7'h0, gTx}, {7'h0, x});
    if (x) chk({4'h0, gBytes}, {4'h0, b});
    chk({5'h0, gEv}, {5'h0, e});
  endtask
  // a full out transaction followed by the answer window
  task automatic out_xfer(input logic [1:0] ep, input logic [4:0] nb, input logic tg,
                          input logic crc);
    i_uepr_host_model.send_token(uepr_pkg::PID_OUT, ep, 1'b1);
    i_uepr_host_model.data_start();
    i_uepr_host_model.data_end(nb, tg, crc, 1'b1);
    watch(3);
  endtask
  // mode the engine falls back to after an acknowledged transaction
  function automatic logic [3:0] acked(input logic [3:0] m);
    case (m)
      uepr_pkg::MODE_ACK_OUT: acked = uepr_pkg::MODE_NAK_OUT;
      uepr_pkg::MODE_ACK_OUT_STIN: acked = uepr_pkg::MODE_NAK_OUT_STIN;
      uepr_pkg::MODE_ACK_IN: acked = uepr_pkg::MODE_NAK_IN;
      uepr_pkg::MODE_ACK_IN_STOUT: acked = uepr_pkg::MODE_NAK_IN_STOUT;
      default: acked = m;
    endcase
  endfunction
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    test_done();
  end
  // main sequence
  initial begin
    {reset, regWrite, regRead, regAddr, regWrData, n_fail, checks_done} = '0;
    reset = 1'b1;
    void'($urandom(32'hb2ea));
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      chk(v, 8'h00);
    end
    i_uepr_host_model.send_token(uepr_pkg::PID_IN, 2'h1, 1'b1);
    watch(4);
    resp(0, 0, 0, 0, 3'b000);
    // setup on ep0: flag rises at the data phase, mode forced at the end
    wr(3'h0, {4'h0, uepr_pkg::MODE_STATUS_OUT});
    i_uepr_host_model.send_token(uepr_pkg::PID_SETUP, 2'h0, 1'b1);
    i_uepr_host_model.data_start();
    rd(3'h0, v);
    chk(v, 8'h82);
    i_uepr_host_model.data_end(5'h0a, 1'b0, 1'b1, 1'b1);
    watch(3);
    resp(1, uepr_pkg::HS_ACK, 0, 0, 3'b001);
    i_uepr_host_model.send_token(uepr_pkg::PID_IN, 2'h0, 1'b1);
    watch(3);
    resp(1, uepr_pkg::HS_NAK, 0, 0, 3'b001);
    out_xfer(2'h0, 5'h02, 1'b1, 1'b1);
    resp(1, uepr_pkg::HS_NAK, 0, 0, 3'b001);
    // writes while locked: only the setup flag may change
    wr(3'h0, 8'h0f);
    wr(3'h1, 8'h55);
    rd(3'h0, v);
    chk(v, 8'h61);
    rd(3'h1, v);
    chk(v, 8'h4a);
    // firmware reads before writing, so the write lands
    wr(3'h0, {4'h0, uepr_pkg::MODE_ACK_IN_STOUT});
    rd(3'h0, v);
    chk(v, 8'h0f);
    out_xfer(2'h0, uepr_pkg::STATUS_LEN, 1'b1, 1'b1);
    resp(1, uepr_pkg::HS_ACK, 0, 0, 3'b001);
    rd(3'h0, v);
    chk({4'h0, v[3:0]}, {4'h0, acked(uepr_pkg::MODE_ACK_IN_STOUT)});
    out_xfer(2'h0, uepr_pkg::STATUS_LEN, 1'b0, 1'b1);
    resp(1, uepr_pkg::HS_STALL, 0, 0, 3'b001);
    rd(3'h0, v);
    chk({4'h0, v[3:0]}, {4'h0, uepr_pkg::MODE_STALL_INOUT});
    wr(3'h0, {4'h0, uepr_pkg::MODE_IGNORE_INOUT});
    i_uepr_host_model.send_token(uepr_pkg::PID_IN, 2'h0, 1'b1);
    watch(4);
    resp(0, 0, 0, 0, 3'b000);
    rd(3'h0, v);
    chk(v, {4'h0, uepr_pkg::MODE_IGNORE_INOUT});
    // ep0 ack out with status in: setup-accepting modes belong on the control endpoint only
    wr(3'h0, {4'h0, uepr_pkg::MODE_ACK_OUT_STIN});
    out_xfer(2'h0, 5'h04, 1'b0, 1'b1);
    resp(1, uepr_pkg::HS_ACK, 0, 0, 3'b001);
    i_uepr_host_model.send_token(uepr_pkg::PID_IN, 2'h0, 1'b1);
    watch(2);
    resp(0, 0, 1, 4'h0, 3'b000);
    chk({7'h0, gTog}, 8'h00);
    i_uepr_host_model.host_reply(1'b1);
    watch(2);
    resp(0, 0, 0, 0, 3'b001);
    rd(3'h0, v);
    chk(v, {4'h6, uepr_pkg::MODE_NAK_OUT_STIN});
    rd(3'h1, v);
    chk(v, 8'h44);
    // ep1 counted in: wrong address, out token, random counts, stall bit
    wr(3'h2, {4'h0, uepr_pkg::MODE_ACK_IN});
    i_uepr_host_model.send_token(uepr_pkg::PID_IN, 2'h1, 1'b0);
    watch(4);
    resp(0, 0, 0, 0, 3'b000);
    out_xfer(2'h1, 5'h04, 1'b0, 1'b1);
    resp(0, 0, 0, 0, 3'b000);
    for (int i = 0; i < 5; i++) begin
      n = 4'($urandom_range(8));
      t = 1'($urandom());
      wr(3'h2, {4'h0, uepr_pkg::MODE_ACK_IN});
      wr(3'h3, {t, 3'h0, n});
      i_uepr_host_model.send_token(uepr_pkg::PID_IN, 2'h1, 1'b1);
      watch(2);
      resp(0, 0, 1, n, 3'b000);
      chk({7'h0, gTog}, {7'h0, t});
      i_uepr_host_model.host_reply(1'b1);
      watch(2);
      resp(0, 0, 0, 0, 3'b010);
      rd(3'h2, v);
      chk(v, {4'h0, acked(uepr_pkg::MODE_ACK_IN)});
    end
    wr(3'h2, {4'h8, uepr_pkg::MODE_ACK_IN});
    i_uepr_host_model.send_token(uepr_pkg::PID_IN, 2'h1, 1'b1);
    watch(3);
    resp(1, uepr_pkg::HS_STALL, 0, 0, 3'b010);
    // ep2 out: in ignored, oversize, bad crc, then a good packet
    wr(3'h4, {4'h0, uepr_pkg::MODE_ACK_OUT});
    i_uepr_host_model.send_token(uepr_pkg::PID_IN, 2'h2, 1'b1);
    watch(4);
    resp(0, 0, 0, 0, 3'b000);
    out_xfer(2'h2, 5'h0b, 1'b1, 1'b1);
    resp(0, 0, 0, 0, 3'b100);
    out_xfer(2'h2, 5'h06, 1'b1, 1'b0);
    resp(0, 0, 0, 0, 3'b100);
    rd(3'h5, v);
    chk(v, 8'h86);
    out_xfer(2'h2, 5'h05, 1'b1, 1'b1);
    resp(1, uepr_pkg::HS_ACK, 0, 0, 3'b100);
    rd(3'h5, v);
    chk(v, 8'hc5);
    rd(3'h4, v);
    chk(v, {4'h0, acked(uepr_pkg::MODE_ACK_OUT)});
    // ep2 iso out: buffer written and event raised, never a handshake
    wr(3'h4, {4'h0, uepr_pkg::MODE_ISO_OUT});
    out_xfer(2'h2, 5'h07, 1'b0, 1'b1);
    resp(0, 0, 0, 0, 3'b100);
    rd(3'h5, v);
    chk(v, 8'h47);
    // ep2 iso in: counted data; a lost host reply raises nothing and keeps the mode
    wr(3'h4, {4'h0, uepr_pkg::MODE_ISO_IN});
    wr(3'h5, {1'b1, 3'h0, n});
    i_uepr_host_model.send_token(uepr_pkg::PID_IN, 2'h2, 1'b1);
    watch(2);
    resp(0, 0, 1, n, 3'b000);
    i_uepr_host_model.host_reply(1'b0);
    watch(2);
    resp(0, 0, 0, 0, 3'b000);
    rd(3'h4, v);
    chk(v, {4'h0, uepr_pkg::MODE_ISO_IN});
    test_done();
  end
endmodule
`default_nettype wire

// File: bench/uepr_host_model.sv
// host-side packet engine model: tokens, data packets and host replies to our in data
// assumes the bench calls its tasks from one process, one clock domain, after reset
`timescale 1ns/1ps
`default_nettype none
module uepr_host_model (
  // clock
  input wire logic clock,
  // token and data events
  output logic tokenStrobe,
  output logic [1:0] tokenPid,
  output logic [1:0] tokenEp,
  output logic tokenAddrOk,
  output logic dataStart,
  output logic dataEnd,
  output logic [4:0] rxBytes,
  output logic rxToggle,
  output logic rxCrcOk,
  output logic rxErrFree,
  // host reply to in data
  output logic hostAck,
  output logic hostLost
);
  // quiet lines at time zero
  initial begin
    {tokenStrobe, tokenPid, tokenEp, tokenAddrOk, dataStart, dataEnd} = '0;
    {rxBytes, rxToggle, rxCrcOk, rxErrFree, hostAck, hostLost} = '0;
  end
  // one-cycle token; fields are scrambled once released so stale values never look valid
  task automatic send_token(input logic [1:0] pid, input logic [1:0] ep, input logic ok);
    @(posedge clock);
    {tokenStrobe, tokenPid, tokenEp, tokenAddrOk} <= {1'b1, pid, ep, ok};
    @(posedge clock);
    {tokenStrobe, tokenPid, tokenEp, tokenAddrOk} <= {1'b0, ~pid, ~ep, ~ok};
  endtask
  // start of the data packet phase
  task automatic data_start();
    @(posedge clock);
    dataStart <= 1'b1;
    @(posedge clock);
    dataStart <= 1'b0;
  endtask
  // end of packet with its properties, inverted afterwards
  task automatic data_end(input logic [4:0] n, input logic tg, input logic crc, input logic ef);
    @(posedge clock);
    {dataEnd, rxBytes, rxToggle, rxCrcOk, rxErrFree} <= {1'b1, n, tg, crc, ef};
    @(posedge clock);
    {dataEnd, rxBytes, rxToggle, rxCrcOk, rxErrFree} <= {1'b0, ~n, ~tg, ~crc, ~ef};
  endtask
  // host answer to our in data: ack or timeout
  task automatic host_reply(input logic ack);
    @(posedge clock);
    {hostAck, hostLost} <= {ack, ~ack};
    @(posedge clock);
    {hostAck, hostLost} <= 2'b00;
  endtask
endmodule
`default_nettype wire

// File: hw/uepr_pkg.sv
// constants, types and register layout of the usb endpoint mode responder
// assumes one clock, synchronous reset, a plain register port and a token-level packet engine
// How it works
// - mode 0001: ack setup, nak in and out
// - check mode: ack only empty data1 out
// - counted in mode sends count bits 3..0
// - zero-length in mode sends empty packet
// - ignored token gets no handshake at all
// - accepted setup gets ack when valid
// - 1111 acked becomes 1110; 1010, 1110 stay
// - all modes reset to disabled 0000
// - accepted setup forces mode to 0001
// - endpoint 0 has setup, in, out flags
// - only valid transactions answered, others dropped
// - event on valid completion or bad crc
// - valid data: count within size plus two
// - out endpoints ignore in, and reverse
// - in/out flags at end, setup at data
// - endpoint 0 acked: mode, count write-locked
// - bit 7 stall replaces ack handshake
// - acked 1001, 1101, 1011 revert to nak
// - crc error: event fires, data valid cleared
// - out/setup copy received data toggle bit
package uepr_pkg;
  localparam int NUM_EP = 3;
  localparam logic [1:0] EP_LAST = 2'h2;
  // register map: mode of endpoint n at 2n, count at 2n+1
  localparam logic [2:0] OFF_MODE0 = 3'h0;
  localparam logic [2:0] OFF_COUNT0 = 3'h1;
  localparam logic [7:0] RESET_MODE = 8'h00;
  localparam logic [7:0] RESET_COUNT = 8'h00;
  // field positions
  localparam int BIT_STALL = 7;
  localparam int BIT_SETUP = 7;
  localparam int BIT_IN = 6;
  localparam int BIT_OUT = 5;
  localparam int BIT_TOGGLE = 7;
  localparam int BIT_DVAL = 6;
  // sizes in bytes
  localparam logic [4:0] EP_SIZE = 5'h08;
  localparam logic [4:0] CRC_BYTES = 5'h02;
  localparam logic [4:0] STATUS_LEN = 5'h02;
  // mode encodings
  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_NAK_INOUT = 4'h1;
  localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
  localparam logic [3:0] MODE_STALL_INOUT = 4'h3;
  localparam logic [3:0] MODE_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] MODE_ISO_OUT = 4'h5;
  localparam logic [3:0] MODE_STATUS_IN = 4'h6;
  localparam logic [3:0] MODE_ISO_IN = 4'h7;
  localparam logic [3:0] MODE_NAK_OUT = 4'h8;
  localparam logic [3:0] MODE_ACK_OUT = 4'h9;
  localparam logic [3:0] MODE_NAK_OUT_STIN = 4'hA;
  localparam logic [3:0] MODE_ACK_OUT_STIN = 4'hB;
  localparam logic [3:0] MODE_NAK_IN = 4'hC;
  localparam logic [3:0] MODE_ACK_IN = 4'hD;
  localparam logic [3:0] MODE_NAK_IN_STOUT = 4'hE;
  localparam logic [3:0] MODE_ACK_IN_STOUT = 4'hF;
  // token and handshake codes
  localparam logic [1:0] PID_SETUP = 2'h0;
  localparam logic [1:0] PID_IN = 2'h1;
  localparam logic [1:0] PID_OUT = 2'h2;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_HACK = 2'b11
  } uepr_state_type;
  typedef enum logic [3:0] {
    ACT_IGNORE = 4'h0,
    ACT_NAK = 4'h1,
    ACT_STALL = 4'h2,
    ACT_ACK = 4'h3,
    ACT_CHECK = 4'h4,
    ACT_ISO = 4'h5,
    ACT_TX0 = 4'h6,
    ACT_TXCNT = 4'h7,
    ACT_SETUP = 4'h8
  } uepr_act_type;
endpackage

// File: hw/uepr_responder.sv
// endpoint handshake logic of the usb protocol engine: mode decode, mode updates, ep0 lock
// assumes the packet engine delivers token, data and host-ack events as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module uepr_responder (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // token and data events from the packet engine
  input wire logic tokenStrobe,
  input wire logic [1:0] tokenPid,
  input wire logic [1:0] tokenEp,
  input wire logic tokenAddrOk,
  input wire logic dataStart,
  input wire logic dataEnd,
  input wire logic [4:0] rxBytes,
  input wire logic rxToggle,
  input wire logic rxCrcOk,
  input wire logic rxErrFree,
  input wire logic hostAck,
  input wire logic hostLost,
  // answers to the packet engine
  output logic hsStrobe,
  output logic [1:0] hsCode,
  output logic txStrobe,
  output logic [3:0] txBytes,
  output logic txToggle,
  // per-endpoint event pulses
  output logic [uepr_pkg::NUM_EP-1:0] epEvent
);

  typedef struct packed {
    uepr_pkg::uepr_state_type state;
    logic [1:0] ep;
    uepr_pkg::uepr_act_type act;
    logic [uepr_pkg::NUM_EP-1:0][7:0] mode;
    logic [uepr_pkg::NUM_EP-1:0][7:0] count;
    logic lockMode;
    logic lockCount;
    logic [7:0] rdData;
    logic hsStrobe;
    logic [1:0] hsCode;
    logic txStrobe;
    logic [3:0] txBytes;
    logic txToggle;
    logic [uepr_pkg::NUM_EP-1:0] epEvent;
  } uepr_regs_type;

  uepr_regs_type r;
  uepr_regs_type next_r;

  // token decode from the mode table; stall bit only on non-control endpoints
  function automatic uepr_pkg::uepr_act_type decode(input logic [1:0] pid,
                                                    input logic [3:0] m,
                                                    input logic stl);
    uepr_pkg::uepr_act_type a;
    a = uepr_pkg::ACT_IGNORE;
    case (pid)
      uepr_pkg::PID_SETUP: begin
        case (m)
          uepr_pkg::MODE_NAK_INOUT, uepr_pkg::MODE_STATUS_OUT,
          uepr_pkg::MODE_STALL_INOUT, uepr_pkg::MODE_IGNORE_INOUT,
          uepr_pkg::MODE_STATUS_IN, uepr_pkg::MODE_NAK_OUT_STIN,
          uepr_pkg::MODE_ACK_OUT_STIN, uepr_pkg::MODE_NAK_IN_STOUT,
          uepr_pkg::MODE_ACK_IN_STOUT: a = uepr_pkg::ACT_SETUP;
          default: a = uepr_pkg::ACT_IGNORE;
        endcase
      end
      uepr_pkg::PID_IN: begin
        // out-only modes fall to the default and stay silent
        case (m)
          uepr_pkg::MODE_NAK_INOUT, uepr_pkg::MODE_NAK_IN,
          uepr_pkg::MODE_NAK_IN_STOUT: a = uepr_pkg::ACT_NAK;
          uepr_pkg::MODE_STATUS_OUT,
          uepr_pkg::MODE_STALL_INOUT: a = uepr_pkg::ACT_STALL;
          uepr_pkg::MODE_STATUS_IN, uepr_pkg::MODE_NAK_OUT_STIN,
          uepr_pkg::MODE_ACK_OUT_STIN: a = uepr_pkg::ACT_TX0;
          uepr_pkg::MODE_ISO_IN,
          uepr_pkg::MODE_ACK_IN_STOUT: a = uepr_pkg::ACT_TXCNT;
          uepr_pkg::MODE_ACK_IN: a = stl ? uepr_pkg::ACT_STALL : uepr_pkg::ACT_TXCNT;
          default: a = uepr_pkg::ACT_IGNORE;
        endcase
      end
      uepr_pkg::PID_OUT: begin
        case (m)
          uepr_pkg::MODE_NAK_INOUT, uepr_pkg::MODE_NAK_OUT,
          uepr_pkg::MODE_NAK_OUT_STIN: a = uepr_pkg::ACT_NAK;
          uepr_pkg::MODE_STALL_INOUT,
          uepr_pkg::MODE_STATUS_IN: a = uepr_pkg::ACT_STALL;
          uepr_pkg::MODE_ACK_OUT: a = stl ? uepr_pkg::ACT_STALL : uepr_pkg::ACT_ACK;
          uepr_pkg::MODE_ACK_OUT_STIN: a = uepr_pkg::ACT_ACK;
          uepr_pkg::MODE_STATUS_OUT, uepr_pkg::MODE_NAK_IN_STOUT,
          uepr_pkg::MODE_ACK_IN_STOUT: a = uepr_pkg::ACT_CHECK;
          uepr_pkg::MODE_ISO_OUT: a = uepr_pkg::ACT_ISO;
          default: a = uepr_pkg::ACT_IGNORE;
        endcase
      end
      default: a = uepr_pkg::ACT_IGNORE;
    endcase
    return a;
  endfunction

  logic [1:0] regEp;
  logic regMapped;
  logic tokenOk;
  logic rxValid;
  logic [3:0] tokenMode;
  logic tokenStall;
  logic [3:0] countSel;
  logic [7:0] count0;

  assign regEp = regAddr[2:1];
  assign regMapped = (regEp <= uepr_pkg::EP_LAST);
  assign tokenOk = tokenStrobe && tokenAddrOk && (tokenEp <= uepr_pkg::EP_LAST);
  assign tokenMode = r.mode[tokenEp][3:0];
  assign tokenStall = (tokenEp != 2'h0) && r.mode[tokenEp][uepr_pkg::BIT_STALL];
  // oversize packets and failed checks are never answered
  assign rxValid = rxCrcOk && rxErrFree
                   && (rxBytes <= uepr_pkg::EP_SIZE + uepr_pkg::CRC_BYTES);
  assign countSel = r.count[tokenEp][3:0];
  assign count0 = r.count[0];

  // software accesses first, engine updates after, so a hardware set wins a same-cycle clear
  always_comb begin
    next_r = r;
    next_r.hsStrobe = 1'b0;
    next_r.txStrobe = 1'b0;
    next_r.epEvent = '0;
    next_r.rdData = 8'h00;
    if (regRead && regMapped) begin
      next_r.rdData = regAddr[0] ? r.count[regEp] : r.mode[regEp];
      if (regEp == 2'h0 && !regAddr[0]) begin
        next_r.lockMode = 1'b0;
      end
      if (regEp == 2'h0 && regAddr[0]) begin
        next_r.lockCount = 1'b0;
      end
    end
    if (regWrite && regMapped) begin
      if (regAddr[0]) begin
        if (!(regEp == 2'h0 && r.lockCount)) begin
          next_r.count[regEp] = regWrData;
        end
      end else if (regEp == 2'h0 && r.lockMode) begin
        // only the setup flag stays writable under the lock
        next_r.mode[0][uepr_pkg::BIT_SETUP] = regWrData[uepr_pkg::BIT_SETUP];
      end else begin
        next_r.mode[regEp] = regWrData;
      end
    end
    case (r.state)
      uepr_pkg::ST_IDLE: begin
        if (tokenOk) begin
          next_r.ep = tokenEp;
          next_r.act = decode(tokenPid, tokenMode, tokenStall);
          if (tokenPid == uepr_pkg::PID_IN) begin
            case (next_r.act)
              uepr_pkg::ACT_NAK, uepr_pkg::ACT_STALL: begin
                next_r.hsStrobe = 1'b1;
                next_r.hsCode = (next_r.act == uepr_pkg::ACT_NAK) ? uepr_pkg::HS_NAK
                                                                  : uepr_pkg::HS_STALL;
                next_r.epEvent[tokenEp] = 1'b1;
                if (tokenEp == 2'h0) begin
                  next_r.mode[0][uepr_pkg::BIT_IN] = 1'b1;
                end
              end
              uepr_pkg::ACT_TX0, uepr_pkg::ACT_TXCNT: begin
                next_r.txStrobe = 1'b1;
                next_r.txBytes = (next_r.act == uepr_pkg::ACT_TX0) ? 4'h0 : countSel;
                next_r.txToggle = r.count[tokenEp][uepr_pkg::BIT_TOGGLE];
                next_r.state = uepr_pkg::ST_HACK;
              end
              default: next_r.state = uepr_pkg::ST_IDLE;
            endcase
          end else if (next_r.act != uepr_pkg::ACT_IGNORE) begin
            next_r.state = uepr_pkg::ST_DATA;
          end
        end
      end
      uepr_pkg::ST_DATA: begin
        // setup flag goes up as the data packet starts, ahead of the end update
        if (r.act == uepr_pkg::ACT_SETUP && r.ep == 2'h0
            && (dataStart || r.mode[0][uepr_pkg::BIT_SETUP])) begin
          next_r.mode[0][uepr_pkg::BIT_SETUP] = 1'b1;
        end
        if (dataEnd) begin
          next_r.state = uepr_pkg::ST_IDLE;
          case (r.act)
            uepr_pkg::ACT_SETUP, uepr_pkg::ACT_ACK, uepr_pkg::ACT_ISO: begin
              // the buffer is written whatever the outcome, so status always reports it
              next_r.count[r.ep] = {rxToggle, rxValid, 2'b00, rxBytes[3:0]};
              next_r.epEvent[r.ep] = 1'b1;
              if (rxValid && r.act != uepr_pkg::ACT_ISO) begin
                next_r.hsStrobe = 1'b1;
                next_r.hsCode = uepr_pkg::HS_ACK;
                if (r.act == uepr_pkg::ACT_SETUP) begin
                  next_r.mode[r.ep][3:0] = uepr_pkg::MODE_NAK_INOUT;
                end else begin
                  next_r.mode[r.ep][0] = 1'b0;
                  if (r.ep == 2'h0) begin
                    next_r.mode[0][uepr_pkg::BIT_OUT] = 1'b1;
                  end
                end
                if (r.ep == 2'h0) begin
                  next_r.lockMode = 1'b1;
                  next_r.lockCount = 1'b1;
                end
              end
            end
            uepr_pkg::ACT_NAK, uepr_pkg::ACT_STALL: begin
              if (rxValid) begin
                next_r.hsStrobe = 1'b1;
                next_r.hsCode = (r.act == uepr_pkg::ACT_NAK) ? uepr_pkg::HS_NAK
                                                             : uepr_pkg::HS_STALL;
                next_r.epEvent[r.ep] = 1'b1;
                if (r.ep == 2'h0) begin
                  next_r.mode[0][uepr_pkg::BIT_OUT] = 1'b1;
                end
              end
            end
            uepr_pkg::ACT_CHECK: begin
              if (rxValid) begin
                next_r.hsStrobe = 1'b1;
                next_r.epEvent[r.ep] = 1'b1;
                if (r.ep == 2'h0) begin
                  next_r.mode[0][uepr_pkg::BIT_OUT] = 1'b1;
                end
                if (rxBytes == uepr_pkg::STATUS_LEN && rxToggle) begin
                  next_r.hsCode = uepr_pkg::HS_ACK;
                  next_r.count[r.ep] = {rxToggle, 1'b1, 2'b00, rxBytes[3:0]};
                  if (r.mode[r.ep][3:0] == uepr_pkg::MODE_ACK_IN_STOUT) begin
                    next_r.mode[r.ep][3:0] = uepr_pkg::MODE_NAK_IN_STOUT;
                  end
                  if (r.ep == 2'h0) begin
                    next_r.lockMode = 1'b1;
                    next_r.lockCount = 1'b1;
                  end
                end else begin
                  next_r.hsCode = uepr_pkg::HS_STALL;
                  next_r.mode[r.ep][3:0] = uepr_pkg::MODE_STALL_INOUT;
                end
              end
            end
            default: next_r.state = uepr_pkg::ST_IDLE;
          endcase
        end else if (tokenStrobe) begin
          // a new token means the data packet never came
          next_r.state = uepr_pkg::ST_IDLE;
        end
      end
      uepr_pkg::ST_HACK: begin
        if (hostAck) begin
          next_r.state = uepr_pkg::ST_IDLE;
          next_r.epEvent[r.ep] = 1'b1;
          // zero-length status modes keep their encoding
          if (r.mode[r.ep][3:0] == uepr_pkg::MODE_ACK_IN
              || r.mode[r.ep][3:0] == uepr_pkg::MODE_ACK_IN_STOUT) begin
            next_r.mode[r.ep][0] = 1'b0;
          end
          if (r.ep == 2'h0) begin
            next_r.mode[0][uepr_pkg::BIT_IN] = 1'b1;
            next_r.lockMode = 1'b1;
            next_r.lockCount = 1'b1;
          end
        end else if (hostLost || tokenStrobe) begin
          next_r.state = uepr_pkg::ST_IDLE;
        end
      end
      default: next_r.state = uepr_pkg::ST_IDLE;
    endcase
  end

  // all state in one register; every mode resets disabled
  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '0;
      r.state <= uepr_pkg::ST_IDLE;
      r.act <= uepr_pkg::ACT_IGNORE;
      r.mode <= {uepr_pkg::NUM_EP{uepr_pkg::RESET_MODE}};
      r.count <= {uepr_pkg::NUM_EP{uepr_pkg::RESET_COUNT}};
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign regRdData = r.rdData;
  assign hsStrobe = r.hsStrobe;
  assign hsCode = r.hsCode;
  assign txStrobe = r.txStrobe;
  assign txBytes = r.txBytes;
  assign txToggle = r.txToggle;
  assign epEvent = r.epEvent;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_nak_inout: assert property (
    (r.state == uepr_pkg::ST_IDLE && tokenOk && tokenPid == uepr_pkg::PID_IN
     && tokenMode == uepr_pkg::MODE_NAK_INOUT) |=> hsStrobe && hsCode == uepr_pkg::HS_NAK)
    else $error("in token in mode 0001 not nakked");
  a_disabled_silent: assert property (
    (r.state == uepr_pkg::ST_IDLE && tokenOk && tokenMode == uepr_pkg::MODE_DISABLE)
    |=> !hsStrobe && !txStrobe ##1 !hsStrobe)
    else $error("disabled endpoint answered");
  a_setup_to_nak: assert property (
    (r.state == uepr_pkg::ST_DATA && r.act == uepr_pkg::ACT_SETUP && dataEnd && rxValid)
    |=> hsCode == uepr_pkg::HS_ACK && r.mode[$past(r.ep)][3:0] == uepr_pkg::MODE_NAK_INOUT)
    else $error("setup did not force mode 0001");
  a_check_ack: assert property (
    (r.state == uepr_pkg::ST_DATA && r.act == uepr_pkg::ACT_CHECK && dataEnd && rxValid
     && rxBytes == uepr_pkg::STATUS_LEN && rxToggle) |=> hsStrobe && hsCode == uepr_pkg::HS_ACK)
    else $error("status out not acked");
  a_tx_count: assert property (
    (r.state == uepr_pkg::ST_IDLE && tokenOk && tokenPid == uepr_pkg::PID_IN
     && tokenMode == uepr_pkg::MODE_ISO_IN) |=> txStrobe && txBytes == $past(countSel))
    else $error("counted in sent wrong byte count");
  a_tx_zero: assert property (
    txStrobe && r.act == uepr_pkg::ACT_TX0 |-> txBytes == 4'h0 && r.state == uepr_pkg::ST_HACK)
    else $error("zero-length in carried bytes");
  a_lock_holds: assert property (
    (r.lockCount && regWrite && regAddr == uepr_pkg::OFF_COUNT0
     && r.state == uepr_pkg::ST_IDLE) |=> count0 == $past(count0))
    else $error("locked count accepted a write");
  a_bad_crc: assert property (
    (r.state == uepr_pkg::ST_DATA && (r.act == uepr_pkg::ACT_SETUP || r.act == uepr_pkg::ACT_ACK)
     && dataEnd && !rxCrcOk) |=> epEvent[$past(r.ep)] && !hsStrobe)
    else $error("crc error handled wrongly");
  a_oversize: assert property (
    (r.state == uepr_pkg::ST_DATA && dataEnd && rxBytes > uepr_pkg::EP_SIZE + uepr_pkg::CRC_BYTES)
    |=> !hsStrobe)
    else $error("oversize packet answered");
  a_setup_early: assert property (
    (r.state == uepr_pkg::ST_DATA && r.act == uepr_pkg::ACT_SETUP && r.ep == 2'h0 && dataStart)
    |=> r.mode[0][uepr_pkg::BIT_SETUP])
    else $error("setup flag late");
endmodule
`default_nettype wire
